// >>> hw/usart_core.sv
// usart_core.sv: usart clock generation, transmitter and buffered receiver
// assumes: ahb-lite single slave on hclk; rxd and transfer clock pin are asynchronous
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`include "usart_core_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Function
// - baud counter runs on hclk, reloads at zero and on low-byte write.
// - one baud tick each time counter reaches zero, except when power reduced, in sync slave mode or on a low-byte write.
// - transmitter divides tick by 16, 8 or 2 per mode.
// - receiver recovery uses raw tick with 16 or 8 state counter; sync mode samples on the clock edge.
// - divisor is 12 bits from high and low parts, 0 to 4095.
// - sync_select picks async or sync; pin direction picks master or slave.
// - transfer clock pin used only in synchronous mode.
// - double speed receiver counts 8 ticks per bit, sampling once at mid bit.
// - external clock is synchronised then edge detected before use.
// - receive sampled on edge opposite to transmit change edge.
// - polarity clear: change on rise, sample on fall; set swaps.
// - receive buffer is two-entry fifo popped by each data read.
// - error flags and ninth bit stored with each fifo entry.
// - full fifo keeps finished character in a holding register until a read frees a slot or next start.
// - one transmit buffer so queued character follows without gap.
// - three interrupt conditions: tx complete, tx empty, rx complete.
// - receiver flags frame, overrun, parity errors; transmitter makes parity.
// - 5 to 9 data bits and 1 or 2 stop bits.
// - frame is low start, data lsb first, parity, stops; idle high.
// - parity is xor of data bits, inverted for odd.
// - only first stop bit checked for frame error.
module usart_core
  import usart_core_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        xfer_clk_pin_i,
  output logic             xfer_clk_pin_o,
  output logic             xfer_clk_pin_oe_n,
  output logic             irq_rx_complete,
  output logic             irq_tx_complete,
  output logic             irq_tx_empty
);

  // ****************************************
  // register bus
  // ****************************************
  logic        acc_ok;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        wr_data;
  logic        wr_csa;
  logic        wr_csb;
  logic        wr_csc;
  logic        wr_low;
  logic        wr_high;
  logic        wr_power;
  logic        rd_data;
  logic [31:0] hrdata_q;
  logic [7:0]  rd_val;

  logic        double_speed_q;
  logic [7:0]  csb_q;
  logic [7:0]  csc_q;
  logic [3:0]  baud_divisor_high_q;
  logic [11:0] baud_divisor_q;
  logic        power_reduce_bit_q;

  assign acc_ok    = hsel & htrans[1] & hready;
  assign wr_data   = wr_pend_q & (wr_addr_q == `OFF_DATA);
  assign wr_csa    = wr_pend_q & (wr_addr_q == `OFF_CSA);
  assign wr_csb    = wr_pend_q & (wr_addr_q == `OFF_CSB);
  assign wr_csc    = wr_pend_q & (wr_addr_q == `OFF_CSC);
  assign wr_low    = wr_pend_q & (wr_addr_q == `OFF_BAUD_LOW);
  assign wr_high   = wr_pend_q & (wr_addr_q == `OFF_BAUD_HIGH);
  assign wr_power  = wr_pend_q & (wr_addr_q == `OFF_POWER);
  assign rd_data   = acc_ok & ~hwrite & (haddr[7:0] == `OFF_DATA) & (haddr[31:8] == 24'h000000);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= acc_ok & hwrite & (haddr[31:8] == 24'h000000);
      wr_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      double_speed_q      <= 1'b0;
      csb_q               <= 8'h00;
      csc_q               <= `RST_CSC;
      baud_divisor_high_q <= 4'h0;
      baud_divisor_q      <= `RST_DIVISOR;
      power_reduce_bit_q  <= `RST_POWER;
    end
    else
    begin
      if (wr_csa)
        double_speed_q <= hwdata[`CSA_DOUBLE];
      if (wr_csb)
        csb_q <= hwdata[7:0];
      if (wr_csc)
        csc_q <= hwdata[7:0];
      if (wr_high)
        baud_divisor_high_q <= hwdata[3:0];
      if (wr_low)
        baud_divisor_q <= {baud_divisor_high_q, hwdata[7:0]};
      if (wr_power)
        power_reduce_bit_q <= hwdata[0];
    end
  end

  // ****************************************
  // mode decode
  // ****************************************
  logic       en;
  logic       sync_mode;
  logic       master;
  logic       slave;
  logic       pol;
  logic [3:0] os_last;
  logic [3:0] os_mid;
  logic [2:0] char_size;
  logic [3:0] nbits;
  logic       par_en;
  logic       par_odd;
  logic       tx_en;
  logic       rx_en;

  assign en        = ~power_reduce_bit_q;
  assign sync_mode = csc_q[`CSC_SYNC];
  assign master    = sync_mode & csc_q[`CSC_CLK_DIR];
  assign slave     = sync_mode & ~csc_q[`CSC_CLK_DIR];
  assign pol       = csc_q[`CSC_POLARITY];
  assign os_last   = double_speed_q ? 4'h7 : 4'hF;
  assign os_mid    = double_speed_q ? 4'h3 : 4'h7;
  assign char_size = {csb_q[`CSB_SIZE_MSB], csc_q[`CSC_SIZE_HI], csc_q[`CSC_SIZE_LO]};
  assign nbits     = (char_size == 3'h7) ? 4'h9 : (char_size[2] ? 4'h8 : {2'b01, char_size[1:0]} + 4'h1);
  assign par_en    = csc_q[`CSC_PAR_HI];
  assign par_odd   = csc_q[`CSC_PAR_LO];
  assign tx_en     = en & csb_q[`CSB_TX_EN];
  assign rx_en     = en & csb_q[`CSB_RX_EN];

  // ****************************************
  // baud generator
  // ****************************************
  logic [11:0] baud_cnt_q;
  logic        baud_tick;

  assign baud_tick = en & ~slave & ~wr_low & (baud_cnt_q == 12'h000);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      baud_cnt_q <= `RST_DIVISOR;
    else if (wr_low)
      baud_cnt_q <= {baud_divisor_high_q, hwdata[7:0]};
    else if (baud_cnt_q == 12'h000)
      baud_cnt_q <= baud_divisor_q;
    else
      baud_cnt_q <= baud_cnt_q - 12'h001;
  end

  // ****************************************
  // transfer clock and rxd synchronisers
  // ****************************************
  logic xck_s1_q;
  logic xck_s2_q;
  logic xck_s3_q;
  logic rxd_s1_q;
  logic rxd_s2_q;
  logic xck_out_q;
  logic xck_rise;
  logic xck_fall;
  logic chg_edge;
  logic smp_edge;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      xck_s1_q <= 1'b0;
      xck_s2_q <= 1'b0;
      xck_s3_q <= 1'b0;
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
    end
    else
    begin
      xck_s1_q <= xfer_clk_pin_i;
      xck_s2_q <= xck_s1_q;
      xck_s3_q <= xck_s2_q;
      rxd_s1_q <= rxd;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  // master clock toggles per tick: a full period is two ticks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      xck_out_q <= 1'b0;
    else if (!master)
      xck_out_q <= pol;
    else if (baud_tick)
      xck_out_q <= ~xck_out_q;
  end

  assign xck_rise = master ? (baud_tick & ~xck_out_q) : (slave & en & xck_s2_q & ~xck_s3_q);
  assign xck_fall = master ? (baud_tick & xck_out_q) : (slave & en & ~xck_s2_q & xck_s3_q);
  assign chg_edge = pol ? xck_fall : xck_rise;
  assign smp_edge = pol ? xck_rise : xck_fall;

  assign xfer_clk_pin_o    = xck_out_q;
  assign xfer_clk_pin_oe_n = ~(master & en);

  // ****************************************
  // transmitter
  // ****************************************
  tx_state_t   tx_state_q;
  logic [3:0]  tx_os_q;
  logic        tx_step;
  logic        tx_buf_full_q;
  logic [8:0]  tx_buf_q;
  logic [8:0]  tx_sh_q;
  logic [3:0]  tx_cnt_q;
  logic        tx_par_q;
  logic        txd_q;
  logic        tx_complete_q;
  logic        tx_end;
  logic        tx_done_ev;
  logic [8:0]  size_mask;

  assign size_mask = 9'h1FF >> (4'h9 - nbits);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tx_os_q <= 4'h0;
    else if (!baud_tick || sync_mode)
      tx_os_q <= tx_os_q;
    else if (tx_os_q >= os_last)
      tx_os_q <= 4'h0;
    else
      tx_os_q <= tx_os_q + 4'h1;
  end

  assign tx_step = sync_mode ? chg_edge : (baud_tick & (tx_os_q >= os_last));
  assign tx_end  = (tx_state_q == TX_STOP2) || ((tx_state_q == TX_STOP1) && !csc_q[`CSC_STOP2]);
  assign tx_done_ev = tx_en & tx_step & tx_end & ~tx_buf_full_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_state_q <= TX_IDLE;
      tx_sh_q    <= 9'h000;
      tx_cnt_q   <= 4'h0;
      tx_par_q   <= 1'b0;
      txd_q      <= 1'b1;
    end
    else if (!tx_en)
    begin
      tx_state_q <= TX_IDLE;
      txd_q      <= 1'b1;
    end
    else if (tx_step)
    begin
      case (tx_state_q)
        TX_IDLE, TX_STOP1, TX_STOP2:
        begin
          if (tx_state_q == TX_STOP1 && csc_q[`CSC_STOP2])
          begin
            txd_q      <= 1'b1;
            tx_state_q <= TX_STOP2;
          end
          else if (tx_buf_full_q)
          begin
            txd_q      <= 1'b0;
            tx_sh_q    <= tx_buf_q & size_mask;
            tx_par_q   <= (^(tx_buf_q & size_mask)) ^ par_odd;
            tx_cnt_q   <= 4'h0;
            tx_state_q <= TX_START;
          end
          else
          begin
            txd_q      <= 1'b1;
            tx_state_q <= TX_IDLE;
          end
        end
        TX_START, TX_DATA:
        begin
          if (tx_cnt_q == nbits)
          begin
            txd_q      <= par_en ? tx_par_q : 1'b1;
            tx_state_q <= par_en ? TX_PAR : TX_STOP1;
          end
          else
          begin
            txd_q      <= tx_sh_q[0];
            tx_sh_q    <= tx_sh_q >> 1;
            tx_cnt_q   <= tx_cnt_q + 4'h1;
            tx_state_q <= TX_DATA;
          end
        end
        TX_PAR:
        begin
          txd_q      <= 1'b1;
          tx_state_q <= TX_STOP1;
        end
        default:
        begin
          txd_q      <= 1'b1;
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_buf_full_q <= 1'b0;
      tx_buf_q      <= 9'h000;
    end
    else if (wr_data && !tx_buf_full_q)
    begin
      tx_buf_full_q <= 1'b1;
      tx_buf_q      <= {csb_q[`CSB_TX_NINTH], hwdata[7:0]};
    end
    else if (tx_en && tx_step && (tx_state_q == TX_IDLE || tx_end))
      tx_buf_full_q <= 1'b0;
  end

  // set wins over the write-one clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tx_complete_q <= 1'b0;
    else if (tx_done_ev)
      tx_complete_q <= 1'b1;
    else if (wr_csa && hwdata[`CSA_TX_COMPLETE])
      tx_complete_q <= 1'b0;
  end

  assign txd = txd_q;

  // ****************************************
  // receiver
  // ****************************************
  rx_state_t   rx_state_q;
  logic [3:0]  rx_os_q;
  logic        rx_smp;
  logic        rx_begin;
  logic [8:0]  rx_sh_q;
  logic [3:0]  rx_cnt_q;
  logic        rx_perr_q;
  logic        rx_held_q;
  logic [11:0] rx_held_ent_q;
  logic        rx_ovr_q;
  logic        rx_done;
  logic [11:0] rx_ent;
  logic [11:0] fifo_q [2];
  logic        fifo_wp_q;
  logic        fifo_rp_q;
  logic [1:0]  fifo_cnt_q;
  logic        push;
  logic        pop;
  logic [11:0] push_ent;
  logic [11:0] head;

  // async: counter of 16 or 8 ticks, sample at mid bit; sync: sample edge
  assign rx_smp   = sync_mode ? smp_edge : (baud_tick & (rx_os_q == os_mid));
  assign rx_begin = rx_en & (rx_state_q == RX_IDLE) & ~rxd_s2_q & (sync_mode ? smp_edge : baud_tick);
  assign rx_done  = rx_en & rx_smp & (rx_state_q == RX_STOP);
  assign rx_ent   = {par_en & rx_perr_q, rx_ovr_q, ~rxd_s2_q, rx_sh_q};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rx_os_q <= 4'h0;
    else if (rx_begin)
      rx_os_q <= 4'h0;
    else if (baud_tick)
      rx_os_q <= (rx_os_q >= os_last) ? 4'h0 : rx_os_q + 4'h1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_state_q <= RX_IDLE;
      rx_sh_q    <= 9'h000;
      rx_cnt_q   <= 4'h0;
      rx_perr_q  <= 1'b0;
    end
    else if (!rx_en)
      rx_state_q <= RX_IDLE;
    else if (rx_begin)
    begin
      rx_sh_q    <= 9'h000;
      rx_cnt_q   <= 4'h0;
      rx_perr_q  <= par_odd;
      rx_state_q <= sync_mode ? RX_DATA : RX_START;
    end
    else if (rx_smp)
    begin
      case (rx_state_q)
        RX_START:
          rx_state_q <= rxd_s2_q ? RX_IDLE : RX_DATA;               // false start rejected
        RX_DATA:
        begin
          rx_sh_q[rx_cnt_q] <= rxd_s2_q;
          rx_perr_q         <= rx_perr_q ^ rxd_s2_q;
          rx_cnt_q          <= rx_cnt_q + 4'h1;
          if (rx_cnt_q + 4'h1 == nbits)
            rx_state_q <= par_en ? RX_PAR : RX_STOP;
        end
        RX_PAR:
        begin
          rx_perr_q  <= rx_perr_q ^ rxd_s2_q;
          rx_state_q <= RX_STOP;
        end
        RX_STOP:
          rx_state_q <= RX_IDLE;
        default:
          rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // parity error term: accumulated xor of par_odd, data and parity is nonzero
  assign push     = (rx_done && !rx_held_q && (fifo_cnt_q != 2'd2 || pop)) || (rx_held_q && fifo_cnt_q != 2'd2);
  assign push_ent = rx_held_q ? rx_held_ent_q : rx_ent;
  assign pop      = rd_data & (fifo_cnt_q != 2'd0);
  assign head     = fifo_q[fifo_rp_q];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_held_q     <= 1'b0;
      rx_held_ent_q <= 12'h000;
      rx_ovr_q      <= 1'b0;
    end
    else
    begin
      if (rx_held_q && fifo_cnt_q != 2'd2)
        rx_held_q <= 1'b0;
      else if (rx_held_q && rx_begin)
      begin
        rx_held_q <= 1'b0;
        rx_ovr_q  <= 1'b1;
      end
      if (rx_done && !push)
      begin
        rx_held_q     <= 1'b1;
        rx_held_ent_q <= rx_ent;
      end
      if (push && !rx_held_q)
        rx_ovr_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk)
  begin
    if (push)
      fifo_q[fifo_wp_q] <= push_ent;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fifo_wp_q  <= 1'b0;
      fifo_rp_q  <= 1'b0;
      fifo_cnt_q <= 2'd0;
    end
    else
    begin
      if (push)
        fifo_wp_q <= ~fifo_wp_q;
      if (pop)
        fifo_rp_q <= ~fifo_rp_q;
      fifo_cnt_q <= fifo_cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // ****************************************
  // read mux and interrupt conditions
  // ****************************************
  always_comb
  begin
    rd_val = 8'h00;
    case (haddr[7:0])
      `OFF_DATA:
        rd_val = (fifo_cnt_q != 2'd0) ? head[7:0] : 8'h00;
      `OFF_CSA:
        rd_val = {fifo_cnt_q != 2'd0, tx_complete_q, ~tx_buf_full_q,
                  head[9] & (fifo_cnt_q != 2'd0), head[10] & (fifo_cnt_q != 2'd0),
                  head[11] & (fifo_cnt_q != 2'd0), double_speed_q, 1'b0};
      `OFF_CSB:
        rd_val = {csb_q[7:2], head[8] & (fifo_cnt_q != 2'd0), csb_q[0]};
      `OFF_CSC:
        rd_val = csc_q;
      `OFF_BAUD_LOW:
        rd_val = baud_divisor_q[7:0];
      `OFF_BAUD_HIGH:
        rd_val = {4'h0, baud_divisor_high_q};
      `OFF_POWER:
        rd_val = {7'h00, power_reduce_bit_q};
      default:
        rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= 32'h00000000;
    else if (acc_ok && !hwrite)
      hrdata_q <= (haddr[31:8] == 24'h000000) ? {24'h000000, rd_val} : 32'h00000000;
  end

  assign irq_rx_complete = csb_q[`CSB_RX_IE] & (fifo_cnt_q != 2'd0);
  assign irq_tx_complete = csb_q[`CSB_TXC_IE] & tx_complete_q;
  assign irq_tx_empty    = csb_q[`CSB_TXE_IE] & ~tx_buf_full_q;

endmodule // usart_core

`default_nettype wire

// >>> hw/usart_core_defines.svh
// usart_core_defines.svh: register offsets, field positions and reset values
// assumes: included by the transceiver core, 32-bit ahb-lite word map
`ifndef USART_CORE_DEFINES_SVH
`define USART_CORE_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFF_DATA        8'h00
`define OFF_CSA         8'h04
`define OFF_CSB         8'h08
`define OFF_CSC         8'h0C
`define OFF_BAUD_LOW    8'h10
`define OFF_BAUD_HIGH   8'h14
`define OFF_POWER       8'h18

// ****************************************
// ctrl_status_a fields
// ****************************************
`define CSA_RX_COMPLETE 7
`define CSA_TX_COMPLETE 6
`define CSA_TX_EMPTY    5
`define CSA_FRAME_ERR   4
`define CSA_OVERRUN     3
`define CSA_PARITY_ERR  2
`define CSA_DOUBLE      1

// ****************************************
// ctrl_status_b fields
// ****************************************
`define CSB_RX_IE       7
`define CSB_TXC_IE      6
`define CSB_TXE_IE      5
`define CSB_RX_EN       4
`define CSB_TX_EN       3
`define CSB_SIZE_MSB    2
`define CSB_RX_NINTH    1
`define CSB_TX_NINTH    0

// ****************************************
// ctrl_status_c fields
// ****************************************
`define CSC_CLK_DIR     7
`define CSC_SYNC        6
`define CSC_PAR_HI      5
`define CSC_PAR_LO      4
`define CSC_STOP2       3
`define CSC_SIZE_HI     2
`define CSC_SIZE_LO     1
`define CSC_POLARITY    0

// ****************************************
// reset values
// ****************************************
`define RST_CSC         8'h06
`define RST_POWER       1'b1
`define RST_DIVISOR     12'h000

`endif

// >>> hw/usart_core_pkg.sv
// usart_core_pkg.sv: state types of the transceiver core
// assumes: nothing beyond a systemverilog compiler
package usart_core_pkg;

  typedef enum logic [2:0]
  {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b011,
    TX_PAR   = 3'b010,
    TX_STOP1 = 3'b110,
    TX_STOP2 = 3'b111
  } tx_state_t;

  typedef enum logic [2:0]
  {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b011,
    RX_PAR   = 3'b010,
    RX_STOP  = 3'b110
  } rx_state_t;

endpackage

// >>> testbench/usart_core_properties.sv
// usart_core_properties.sv: port assertions for usart_core
// assumes: bound to usart_core, shadows control writes seen on the bus
`timescale 1ns/1ps
`default_nettype none
module usart_core_properties
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        txd,
  input wire logic        xfer_clk_pin_oe_n,
  input wire logic        irq_rx_complete,
  input wire logic        irq_tx_complete,
  input wire logic        irq_tx_empty
);
  logic       take;
  logic       wc_q;
  logic       wb_q;
  logic [7:0] csc_q;
  logic [7:0] csb_q;
  assign take = hsel && htrans[1] && hready && hwrite && haddr[31:8] == 24'h0;
  // ****
  // shadow of control registers
  // ****
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wc_q  <= 1'h0;
      wb_q  <= 1'h0;
      csc_q <= 8'h06;
      csb_q <= 8'h00;
    end
    else
    begin
      wc_q <= take && haddr[7:0] == 8'h0C;
      wb_q <= take && haddr[7:0] == 8'h08;
      if (wc_q)
        csc_q <= hwdata[7:0];
      if (wb_q)
        csb_q <= hwdata[7:0];
    end
  end
  // ****
  // properties
  // ****
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_async_fall;
    !csc_q[6] ##0 $fell(txd);
  endsequence
  a_resp_okay: assert property (hresp == 1'h0)
    else $error("bus error response");
  a_ready_high: assert property (hreadyout)
    else $error("wait state inserted");
  a_rdata_byte: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_clk_pin_idle: assert property (!(csc_q[7] && csc_q[6]) && $stable(csc_q) |-> xfer_clk_pin_oe_n)
    else $error("clock pin driven outside sync master");
  a_idle_after_reset: assert property ($rose(hresetn) |-> txd [*2])
    else $error("line not idle after reset");
  a_start_min: assert property (s_async_fall |=> !txd [*7])
    else $error("start bit too short");
  a_irq_masked: assert property (csb_q[7:5] == 3'h0 && $stable(csb_q) |-> !(irq_rx_complete || irq_tx_complete || irq_tx_empty))
    else $error("interrupt while disabled");
endmodule // usart_core_properties
bind usart_core usart_core_properties u_props
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .txd(txd),
  .xfer_clk_pin_oe_n(xfer_clk_pin_oe_n), .irq_rx_complete(irq_rx_complete),
  .irq_tx_complete(irq_tx_complete), .irq_tx_empty(irq_tx_empty)
);
`default_nettype wire

// >>> testbench/remote_serial_model.sv
// remote_serial_model.sv: far-side serial transmitter on the receive line
// assumes: caller gives the bit period in hclk cycles
`timescale 1ns/1ps
`default_nettype none
module remote_serial_model
(
  input wire logic hclk,
  output var logic rxd
);
  initial rxd = 1'h1;
  task automatic send(input logic [7:0] b, input logic stop, input int bp);
    logic [9:0] f;
    f = {stop, b, 1'h0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge hclk);
      rxd <= f[i];
      repeat (bp - 1) @(posedge hclk);
    end
    @(posedge hclk);
    rxd <= 1'h1;
  endtask
endmodule // remote_serial_model
`default_nettype wire

// >>> testbench/test_usart_clock_and_rx_buffer.sv
// test_usart_clock_and_rx_buffer.sv: self-checking bench for usart_core
// assumes: design, checker and remote_serial_model compiled first
`timescale 1ns/1ps
`default_nettype none
module test_usart_clock_and_rx_buffer;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        rxd, txd, xck_i, xck_o, xck_oe_n, irq_rx, irq_txc, irq_txe;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, r, seed;
  int          miscompares, check_count, bp;
  assign hready = hreadyout;
  initial
  begin
    hclk = 1'h0;
    forever #4 hclk = ~hclk;
  end
  usart_core dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .rxd(rxd), .txd(txd), .xfer_clk_pin_i(xck_i), .xfer_clk_pin_o(xck_o),
    .xfer_clk_pin_oe_n(xck_oe_n), .irq_rx_complete(irq_rx), .irq_tx_complete(irq_txc), .irq_tx_empty(irq_txe)
  );
  remote_serial_model peer (.hclk(hclk), .rxd(rxd));
  // ****
  // helpers
  // ****
  task automatic results;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tmo;
    miscompares++;
    results();
  endtask
  task automatic wt;
    int n;
    n = 0;
    do @(posedge hclk); while (hready !== 1'h1 && ++n < 50);
    if (n >= 50)
      tmo();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dv);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wt();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= dv;
    wt();
    r = hrdata;
  endtask
  task automatic cap(input int nb, output logic [31:0] v);
    int n;
    n = 0;
    v = '0;
    while (txd !== 1'h0 && ++n < 20000) @(posedge hclk);
    if (n >= 20000)
      tmo();
    repeat (bp / 2) @(posedge hclk);
    for (int i = 0; i < nb; i++)
    begin
      v[i] = txd;
      repeat (bp) @(posedge hclk);
    end
  endtask
  function automatic logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected frame: start, data lsb first, optional parity, one stop
  function automatic logic [31:0] frame(input logic [7:0] b, input logic [1:0] pm);
    frame = 32'({1'h1, b, 1'h0});
    if (pm[1])
      frame = 32'({1'h1, ^b ^ pm[0], b, 1'h0});
  endfunction
  // ****
  // main sequence
  // ****
  initial
  begin
    logic [7:0]  b1, b2;
    logic [7:0]  q[3];
    logic [1:0]  pm;
    logic [31:0] v;
    int          l, d, n;
    seed = 32'h10BA9;
    miscompares = 0;
    check_count = 0;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, xck_i} = '0;
    hsize = 3'h2;
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    bus(0, 8'h0C, 0); chk(r, 32'h06);
    bus(0, 8'h18, 0); chk(r, 32'h01);
    bus(0, 8'h40, 0); chk(r, 32'h00);
    d = int'(rnd() % 3);
    bus(1, 8'h18, 0);
    bus(1, 8'h14, 0);
    bus(1, 8'h10, 32'(d));
    bus(1, 8'h08, 32'hF8);
    @(posedge hclk);
    chk(irq_txe, 1'h1);
    for (int m = 0; m < 4; m++)
    begin
      pm = (m == 1) ? 2'h2 : (m == 2) ? 2'h3 : 2'h0;
      bp = ((m == 3) ? 8 : 16) * (d + 1);
      l = pm[1] ? 11 : 10;
      bus(1, 8'h0C, 32'({pm, 4'h6}));
      bus(1, 8'h04, (m == 3) ? 32'h2 : 32'h0);
      b1 = 8'(rnd());
      b2 = 8'(rnd());
      fork
        cap(2 * l, v);
        begin
          bus(1, 8'h00, 32'(b1));
          n = 0;
          // a write into a full buffer is dropped: wait for it to drain
          do @(posedge hclk); while (irq_txe !== 1'h1 && ++n < 20000);
          if (n >= 20000)
            tmo();
          bus(1, 8'h00, 32'(b2));
        end
      join
      chk(v, frame(b1, pm) | (frame(b2, pm) << l));
    end
    for (int k = 0; k < 3; k++)
    begin
      q[k] = 8'(rnd());
      peer.send(q[k], 1'h1, bp);
    end
    chk(irq_rx, 1'h1);
    chk(irq_txc, 1'h1);
    for (int k = 0; k < 3; k++)
    begin
      bus(0, 8'h04, 0); chk({r[7], r[4], r[3]}, 3'h4);
      bus(0, 8'h00, 0); chk(r, 32'(q[k]));
    end
    peer.send(8'hA5, 1'h0, bp);
    bus(0, 8'h04, 0); chk(r[4], 1'h1);
    bus(0, 8'h00, 0); chk(r, 32'hA5);
    bus(1, 8'h04, 32'h40);
    @(posedge hclk);
    chk(irq_txc, 1'h0);
    // sync slave: remote clock at an eighth of hclk, txd taken on its falling edge
    bus(1, 8'h0C, 32'h46);
    b1 = 8'(rnd());
    bus(1, 8'h00, 32'(b1));
    for (int i = 0; i < 10; i++)
    begin
      xck_i <= 1'h1;
      repeat (4) @(posedge hclk);
      v[i] = txd;
      xck_i <= 1'h0;
      repeat (4) @(posedge hclk);
    end
    chk(32'(v[9:0]), frame(b1, 2'h0));
    bus(1, 8'h0C, 32'hC6);
    repeat (2) @(posedge hclk);
    chk(xck_oe_n, 1'h0);
    v[0] = xck_o;
    repeat (d + 1) @(posedge hclk);
    chk(xck_o, !v[0]);
    bus(1, 8'h0C, 32'h06);
    repeat (2) @(posedge hclk);
    chk(xck_oe_n, 1'h1);
    results();
  end
endmodule // test_usart_clock_and_rx_buffer
`default_nettype wire
